/* File: core/mseq_map.svh */
`ifndef MSEQ_MAP_SVH
`define MSEQ_MAP_SVH
`define MSEQ_PC_W 12
`define MSEQ_STK_DEPTH 3'h6
`define MSEQ_RESET_VEC 12'h000
`define MSEQ_INT_VEC 12'h004
`define MSEQ_OFF_CTRL 8'h00
`define MSEQ_OFF_STAT 8'h04
`define MSEQ_OFF_ACCUM 8'h08
`define MSEQ_OFF_PC_LO 8'h0c
`define MSEQ_CTRL_RUN 0
`define MSEQ_CTRL_EMI 1
`define MSEQ_CTRL_IEN 2
`define MSEQ_CTRL_RST 3'h1
`define MSEQ_DM_IND 8'h00
`define MSEQ_DM_MP 8'h01
`define MSEQ_DM_PC_LO 8'h02
`define MSEQ_DM_STATUS 8'h03
`define MSEQ_ST_C 0
`define MSEQ_ST_AC 1
`define MSEQ_ST_Z 2
`define MSEQ_ST_OV 3
`define MSEQ_NOP_WORD 16'h0000
`define MSEQ_HSIZE_WORD 3'h2
`endif

/* File: core/mseq_pkg.sv */
`include "mseq_map.svh"
package mseq_pkg;
   typedef enum logic [1:0] {
      PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b10, PH_T4 = 2'b11
   } mseq_ph_t;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ALUA = 4'h1, OP_ALUM = 4'h2, OP_MOVI = 4'h3,
      OP_MOVAM = 4'h4, OP_BRANCH = 4'h5, OP_CALL = 4'h6,
      OP_SUB_RETURN = 4'h7, OP_INT_RETURN = 4'h8, OP_SZ = 4'h9,
      OP_SNZ = 4'ha, OP_SDZ = 4'hb, OP_SIZ = 4'hc
   } mseq_op_t;
   typedef enum logic [3:0] {
      FN_ADD = 4'h0, FN_ADC = 4'h1, FN_SUB = 4'h2, FN_SBC = 4'h3,
      FN_DAA = 4'h4, FN_AND = 4'h5, FN_OR = 4'h6, FN_XOR = 4'h7,
      FN_CPL = 4'h8, FN_RR = 4'h9, FN_RRC = 4'ha, FN_RL = 4'hb,
      FN_RLC = 4'hc, FN_INC = 4'hd, FN_DEC = 4'he, FN_PASS = 4'hf
   } mseq_fn_t;
   typedef struct packed {
      mseq_ph_t ph;
      logic [3:0] phase_oh;
      logic [2:0] ctrl;
      logic [`MSEQ_PC_W-1:0] pc;
      logic [15:0] ir;
      logic [7:0] mp;
      logic [7:0] accum;
      logic [7:0] opnd;
      logic [3:0] stat;
      logic [5:0][`MSEQ_PC_W-1:0] stk;
      logic [2:0] lvl;
      logic int_flag;
      logic [`MSEQ_PC_W-1:0] pm_addr;
      logic [7:0] dm_addr;
      logic [7:0] dm_wdata;
      logic dm_we;
      logic [31:0] hrdata;
      logic hready_o;
      logic hresp_o;
      logic wr_pend;
      logic [7:0] wr_addr;
   } mseq_state_t;
endpackage

/* File: core/mseq_alu_if.sv */
`timescale 1ns/1ps
interface mseq_alu_if;
   logic [7:0] a;
   logic [7:0] b;
   mseq_pkg::mseq_fn_t fn;
   logic cin;
   logic aci;
   logic [7:0] y;
   logic c;
   logic ac;
   logic ov;
   modport core (output a, b, fn, cin, aci, input y, c, ac, ov);
   modport alu (input a, b, fn, cin, aci, output y, c, ac, ov);
endinterface

/* File: core/mseq_alu.sv */
`timescale 1ns/1ps
module mseq_alu (
   mseq_alu_if.alu bus // operands in, result and flags out
);
   logic [7:0] bb;
   logic ci;
   logic [8:0] s9;
   logic [4:0] s5;
   always_comb begin
      bb = bus.b;
      ci = 1'b0;
      s9 = 9'h000;
      s5 = 5'h00;
      bus.y = bus.b;
      bus.c = bus.cin;
      bus.ac = bus.aci;
      bus.ov = 1'b0;
      unique case (bus.fn)
         mseq_pkg::FN_ADD, mseq_pkg::FN_ADC,
         mseq_pkg::FN_SUB, mseq_pkg::FN_SBC: begin
            bb = (bus.fn == mseq_pkg::FN_SUB || bus.fn == mseq_pkg::FN_SBC)
               ? ~bus.b : bus.b;
            ci = (bus.fn == mseq_pkg::FN_SUB) ? 1'b1
               : (bus.fn == mseq_pkg::FN_ADD) ? 1'b0 : bus.cin;
            s9 = {1'b0, bus.a} + {1'b0, bb} + {8'h00, ci};
            s5 = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
            bus.y = s9[7:0];
            bus.c = s9[8]; // subtract: carry set means no borrow
            bus.ac = s5[4];
            bus.ov = (bus.a[7] == bb[7]) && (s9[7] != bus.a[7]);
         end
         mseq_pkg::FN_DAA: begin
            s9 = {1'b0, bus.a};
            if (s9[3:0] > 4'h9 || bus.aci) begin
               s9 = s9 + 9'h006;
            end
            if (s9[7:4] > 4'h9 || bus.cin || s9[8]) begin
               s9 = s9 + 9'h060;
            end
            bus.y = s9[7:0];
            bus.c = s9[8] | bus.cin;
         end
         mseq_pkg::FN_AND: bus.y = bus.a & bus.b;
         mseq_pkg::FN_OR: bus.y = bus.a | bus.b;
         mseq_pkg::FN_XOR: bus.y = bus.a ^ bus.b;
         mseq_pkg::FN_CPL: bus.y = ~bus.b;
         mseq_pkg::FN_RR: bus.y = {bus.b[0], bus.b[7:1]};
         mseq_pkg::FN_RRC: begin
            bus.y = {bus.cin, bus.b[7:1]};
            bus.c = bus.b[0];
         end
         mseq_pkg::FN_RL: bus.y = {bus.b[6:0], bus.b[7]};
         mseq_pkg::FN_RLC: begin
            bus.y = {bus.b[6:0], bus.cin};
            bus.c = bus.b[7];
         end
         mseq_pkg::FN_INC: bus.y = bus.b + 8'h01;
         mseq_pkg::FN_DEC: bus.y = bus.b - 8'h01;
         mseq_pkg::FN_PASS: bus.y = bus.b;
      endcase
   end
endmodule

/* File: core/mseq_top.sv */
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module mseq_top (
   input wire logic mclk, // 10 MHz system clock
   input wire logic resetn, // async reset, active low
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [11:0] pm_addr, // program memory address
   input wire logic [15:0] pm_rdata, // program memory word
   output logic [7:0] dm_addr, // data memory address
   input wire logic [7:0] dm_rdata, // data memory read data
   output logic [7:0] dm_wdata, // data memory write data
   output logic dm_we, // data memory write strobe
   input wire logic int_req, // interrupt request level
   output logic [3:0] instruction_phase_clocks // one-hot phase
);
   localparam mseq_pkg::mseq_state_t RST_STATE = '{
      ph: mseq_pkg::PH_T1,
      phase_oh: 4'h1,
      ctrl: `MSEQ_CTRL_RST,
      pc: `MSEQ_RESET_VEC,
      ir: `MSEQ_NOP_WORD,
      hready_o: 1'b1,
      default: '0
   };

   mseq_pkg::mseq_state_t s;
   mseq_pkg::mseq_state_t n;
   mseq_pkg::mseq_op_t op;
   logic bus_hit;
   logic taken;
   logic skip;
   logic wr_mem;
   logic ack;
   logic full;
   logic [7:0] wval;
   logic [7:0] ea;
   logic [15:0] ir_n;

   mseq_alu_if alu_bus ();

   mseq_alu u_alu (
      .bus(alu_bus.alu)
   );

   // internal registers mapped into data space
   function automatic logic is_internal(input logic [7:0] a);
      is_internal = (a == `MSEQ_DM_IND) || (a == `MSEQ_DM_MP)
         || (a == `MSEQ_DM_PC_LO) || (a == `MSEQ_DM_STATUS);
   endfunction

   // push target slot; full stack wraps onto the bottom entry
   function automatic logic [2:0] push_idx(input logic [2:0] l);
      push_idx = (l == `MSEQ_STK_DEPTH) ? 3'h0 : l;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // alu hookup

   assign op = mseq_pkg::mseq_op_t'(s.ir[15:12]);
   assign alu_bus.a = s.accum;
   assign alu_bus.b = s.opnd;
   assign alu_bus.fn = (op == mseq_pkg::OP_SDZ) ? mseq_pkg::FN_DEC
      : (op == mseq_pkg::OP_SIZ) ? mseq_pkg::FN_INC
      : mseq_pkg::mseq_fn_t'(s.ir[11:8]);
   assign alu_bus.cin = s.stat[`MSEQ_ST_C];
   assign alu_bus.aci = s.stat[`MSEQ_ST_AC];
   assign full = (s.lvl == `MSEQ_STK_DEPTH);
   // indirect slot reads through the memory pointer
   assign ea = (s.ir[7:0] == `MSEQ_DM_IND) ? s.mp : s.ir[7:0];

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = s;
      taken = 1'b0;
      skip = 1'b0;
      wr_mem = 1'b0;
      ack = 1'b0;
      wval = alu_bus.y;
      ir_n = pm_rdata;
      bus_hit = hsel && hready && htrans[1]
         && (hsize == `MSEQ_HSIZE_WORD);

      // ahb slave: zero wait, okay only
      n.hready_o = 1'b1;
      n.hresp_o = 1'b0;
      n.wr_pend = bus_hit && hwrite;
      n.wr_addr = haddr[7:0];
      if (bus_hit && !hwrite) begin
         // stack and level pointer deliberately absent from the map
         case (haddr[7:0])
            `MSEQ_OFF_CTRL: n.hrdata = {29'h0, s.ctrl};
            `MSEQ_OFF_STAT: n.hrdata = {8'h00, s.ph, 1'b0, s.int_flag,
               s.stat, 4'h0, s.pc};
            `MSEQ_OFF_ACCUM: n.hrdata = {16'h0000, s.mp, s.accum};
            `MSEQ_OFF_PC_LO: n.hrdata = {24'h000000, s.pc[7:0]};
            default: n.hrdata = 32'h00000000;
         endcase
      end

      // phase sequencing; a halt parks in the first phase
      if (s.ph != mseq_pkg::PH_T1 || s.ctrl[`MSEQ_CTRL_RUN]) begin
         n.ph = mseq_pkg::mseq_ph_t'(s.ph + 2'h1);
      end
      n.phase_oh = 4'h1 << n.ph;

      unique case (s.ph)
         mseq_pkg::PH_T1: begin
            n.dm_we = 1'b0;
            if (s.ctrl[`MSEQ_CTRL_RUN]) begin
               n.pm_addr = s.pc;
               n.pc = s.pc + 12'h001;
               n.dm_addr = ea;
            end
         end
         mseq_pkg::PH_T2: begin
            case (s.dm_addr)
               `MSEQ_DM_IND: n.opnd = 8'h00;
               `MSEQ_DM_MP: n.opnd = s.mp;
               `MSEQ_DM_PC_LO: n.opnd = s.pc[7:0];
               `MSEQ_DM_STATUS: n.opnd = {4'h0, s.stat};
               default: n.opnd = dm_rdata;
            endcase
         end
         mseq_pkg::PH_T3: begin
            // memory and alu settle; nothing is committed here
            n.opnd = s.opnd;
         end
         mseq_pkg::PH_T4: begin
            case (op)
               mseq_pkg::OP_ALUA: n.accum = alu_bus.y;
               mseq_pkg::OP_ALUM: wr_mem = 1'b1;
               mseq_pkg::OP_MOVI: n.accum = s.ir[7:0];
               mseq_pkg::OP_MOVAM: begin
                  wr_mem = 1'b1;
                  wval = s.accum;
               end
               mseq_pkg::OP_BRANCH: begin
                  n.pc = s.ir[11:0];
                  taken = 1'b1;
               end
               mseq_pkg::OP_CALL: begin
                  // overflow when full is accepted, not blocked
                  n.stk[push_idx(s.lvl)] = s.pc - 12'h001;
                  n.lvl = full ? 3'h1 : s.lvl + 3'h1;
                  n.pc = s.ir[11:0];
                  taken = 1'b1;
               end
               mseq_pkg::OP_SUB_RETURN, mseq_pkg::OP_INT_RETURN: begin
                  if (s.lvl != 3'h0) begin
                     n.lvl = s.lvl - 3'h1;
                     n.pc = s.stk[3'(s.lvl - 3'h1)];
                  end else begin
                     n.pc = s.stk[0];
                  end
                  if (op == mseq_pkg::OP_INT_RETURN) begin
                     n.ctrl[`MSEQ_CTRL_EMI] = 1'b1;
                  end
                  taken = 1'b1;
               end
               mseq_pkg::OP_SZ: skip = (s.opnd == 8'h00);
               mseq_pkg::OP_SNZ: skip = (s.opnd != 8'h00);
               mseq_pkg::OP_SDZ, mseq_pkg::OP_SIZ: begin
                  wr_mem = 1'b1;
                  skip = (alu_bus.y == 8'h00);
               end
               default: ;
            endcase

            if (op == mseq_pkg::OP_ALUA || op == mseq_pkg::OP_ALUM
               || op == mseq_pkg::OP_SDZ || op == mseq_pkg::OP_SIZ) begin
               n.stat[`MSEQ_ST_Z] = (alu_bus.y == 8'h00);
               n.stat[`MSEQ_ST_C] = alu_bus.c;
               n.stat[`MSEQ_ST_AC] = alu_bus.ac;
               if (alu_bus.fn <= mseq_pkg::FN_SBC) begin
                  n.stat[`MSEQ_ST_OV] = alu_bus.ov;
               end
            end

            if (wr_mem) begin
               if (s.dm_addr == `MSEQ_DM_MP) begin
                  n.mp = wval;
               end else if (s.dm_addr == `MSEQ_DM_PC_LO) begin
                  // page bits kept, so the jump stays in the page
                  n.pc = {s.pc[11:8], wval};
                  taken = 1'b1;
               end else if (s.dm_addr == `MSEQ_DM_STATUS) begin
                  n.stat = wval[3:0];
               end else if (!is_internal(s.dm_addr)) begin
                  n.dm_we = 1'b1;
                  n.dm_wdata = wval;
               end
            end

            // acknowledge only between instructions with room to push
            ack = s.int_flag && s.ctrl[`MSEQ_CTRL_EMI] && !full
               && !taken && !skip;
            if (ack) begin
               n.stk[s.lvl] = s.pc - 12'h001;
               n.lvl = s.lvl + 3'h1;
               n.pc = `MSEQ_INT_VEC;
               n.ctrl[`MSEQ_CTRL_EMI] = 1'b0;
            end

            // discarded prefetch becomes the dummy cycle
            if (taken || skip || ack) begin
               ir_n = `MSEQ_NOP_WORD;
            end
            n.ir = ir_n;
         end
      endcase

      // request latched even with a full stack; a new request wins
      n.int_flag = (s.int_flag && !ack)
         || (int_req && s.ctrl[`MSEQ_CTRL_IEN]);

      // data phase of a bus write
      if (s.wr_pend && s.wr_addr == `MSEQ_OFF_CTRL) begin
         n.ctrl = hwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s <= RST_STATE;
      end else begin
         s <= n;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hready_o;
   assign hresp = s.hresp_o;
   assign pm_addr = s.pm_addr;
   assign dm_addr = s.dm_addr;
   assign dm_wdata = s.dm_wdata;
   assign dm_we = s.dm_we;
   assign instruction_phase_clocks = s.phase_oh;

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_phase_onehot;
      @(posedge mclk) disable iff (!resetn)
      $onehot(instruction_phase_clocks);
   endproperty
   a_phase_onehot: assert property (p_phase_onehot)
      else $error("phase clocks not one-hot");

   // a halt parks only in the first phase, so the middle never stalls
   property p_phase_step;
      @(posedge mclk) disable iff (!resetn)
      s.ph == mseq_pkg::PH_T2 |=> s.ph == mseq_pkg::PH_T3;
   endproperty
   a_phase_step: assert property (p_phase_step)
      else $error("phase skipped after second phase");

   property p_pc_fetch;
      @(posedge mclk) disable iff (!resetn)
      (s.ph == mseq_pkg::PH_T1 && s.ctrl[`MSEQ_CTRL_RUN])
         |=> (s.pc == $past(s.pc) + 12'h001) && (pm_addr == $past(s.pc));
   endproperty
   a_pc_fetch: assert property (p_pc_fetch)
      else $error("pc not advanced with fetch in first phase");

   property p_branch_dummy;
      @(posedge mclk) disable iff (!resetn)
      (s.ph == mseq_pkg::PH_T4 && op == mseq_pkg::OP_BRANCH)
         |=> (s.pc == $past(s.ir[11:0])) && (s.ir == `MSEQ_NOP_WORD);
   endproperty
   a_branch_dummy: assert property (p_branch_dummy)
      else $error("branch did not load target with dummy cycle");

   property p_page_jump;
      @(posedge mclk) disable iff (!resetn)
      (s.ph == mseq_pkg::PH_T4 && wr_mem && s.dm_addr == `MSEQ_DM_PC_LO)
         |=> (s.pc == {$past(s.pc[11:8]), $past(wval)})
         && (s.ir == `MSEQ_NOP_WORD);
   endproperty
   a_page_jump: assert property (p_page_jump)
      else $error("low byte write left the page or kept prefetch");

   property p_skip_dummy;
      @(posedge mclk) disable iff (!resetn)
      (s.ph == mseq_pkg::PH_T4 && op == mseq_pkg::OP_SZ
         && s.opnd == 8'h00) |=> s.ir == `MSEQ_NOP_WORD;
   endproperty
   a_skip_dummy: assert property (p_skip_dummy)
      else $error("taken skip did not discard prefetched word");

   property p_stack_bound;
      @(posedge mclk) disable iff (!resetn)
      s.lvl <= `MSEQ_STK_DEPTH;
   endproperty
   a_stack_bound: assert property (p_stack_bound)
      else $error("stack level pointer out of range");

   property p_call_push;
      @(posedge mclk) disable iff (!resetn)
      (s.ph == mseq_pkg::PH_T4 && op == mseq_pkg::OP_CALL && !full)
         |=> (s.lvl == $past(s.lvl) + 3'h1)
         && (s.stk[$past(s.lvl)] == $past(s.pc) - 12'h001);
   endproperty
   a_call_push: assert property (p_call_push)
      else $error("call did not push return address");

   property p_full_defer;
      @(posedge mclk) disable iff (!resetn)
      (s.int_flag && full && s.ph == mseq_pkg::PH_T4
         && op != mseq_pkg::OP_SUB_RETURN
         && op != mseq_pkg::OP_INT_RETURN)
         |=> s.int_flag && s.pc != `MSEQ_INT_VEC;
   endproperty
   a_full_defer: assert property (p_full_defer)
      else $error("interrupt acknowledged with full stack");

   property p_alu_write;
      @(posedge mclk) disable iff (!resetn)
      (s.ph == mseq_pkg::PH_T4 && op == mseq_pkg::OP_ALUA)
         |=> (s.accum == $past(alu_bus.y))
         && (s.stat[`MSEQ_ST_Z] == ($past(alu_bus.y) == 8'h00));
   endproperty
   a_alu_write: assert property (p_alu_write)
      else $error("alu result or zero flag not written");

   property p_bus_ready;
      @(posedge mclk) disable iff (!resetn)
      hreadyout && !hresp;
   endproperty
   a_bus_ready: assert property (p_bus_ready)
      else $error("slave stalled or answered error");
endmodule

/* File: tb/mseq_mem_model.sv */
`timescale 1ns/1ps
module mseq_mem_model (
   input wire logic mclk, // system clock
   input wire logic slow, // late program answer inside the fetch window
   input wire logic [11:0] pm_addr, // program fetch address
   output logic [15:0] pm_rdata, // program word
   input wire logic [7:0] dm_addr, // data address
   output logic [7:0] dm_rdata, // data read value
   input wire logic [7:0] dm_wdata, // data write value
   input wire logic dm_we // data write strobe
);
   logic [15:0] prog [0:4095];
   logic [7:0] ram [0:255];
   logic [11:0] last_addr = 12'h000;

   initial begin
      for (int i = 0; i < 4096; i++)
         prog[i] = 16'h0000;
      for (int i = 0; i < 256; i++)
         ram[i] = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // slow mode shows the inverted word for the first cycle after a new
   // address, so a core capturing early picks up garbage, not stale data
   assign pm_rdata = (slow && pm_addr !== last_addr) ? ~prog[pm_addr] :
                     prog[pm_addr];
   assign dm_rdata = ram[dm_addr];

   always @(posedge mclk) begin
      last_addr <= pm_addr;
      if (dm_we)
         ram[dm_addr] <= dm_wdata;
   end
endmodule

/* File: tb/tb_mcu_instruction_sequencer.sv */
`timescale 1ns/1ps
`include "mseq_map.svh"
module tb_mcu_instruction_sequencer;
   localparam logic [11:0] EXP [20] = '{12'h000, 12'h001, 12'h100,
      12'h101, 12'h102, 12'h103, 12'h104, 12'h105, 12'h106, 12'h010,
      12'h011, 12'h106, 12'h107, 12'h108, 12'h109, 12'h10a, 12'h140,
      12'h141, 12'h140, 12'h141};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic int_req = 1'b0;
   logic slow = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [11:0] pm_addr;
   logic [15:0] pm_rdata;
   logic [7:0] dm_addr;
   logic [7:0] dm_rdata;
   logic [7:0] dm_wdata;
   logic dm_we;
   logic [3:0] ph;
   logic [3:0] ph_prev = 4'h1;
   logic was_run = 1'b0;
   logic [11:0] trace [$];
   int n_errors = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic [7:0] x;
   logic [7:0] y;
   logic [8:0] s9;
   int seed_ok;

   always #50 mclk = ~mclk;

   mseq_top dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata),
      .dm_we(dm_we), .int_req(int_req), .instruction_phase_clocks(ph));

   mseq_mem_model mem (.mclk(mclk), .slow(slow), .pm_addr(pm_addr),
      .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rdata(dm_rdata),
      .dm_wdata(dm_wdata), .dm_we(dm_we));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   function automatic logic [8:0] add9(input logic [7:0] a,
                                       input logic [7:0] b);
      return {1'b0, a} + {1'b0, b};
   endfunction

   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   // page 1 main line so a low byte write must keep the upper pc bits
   task automatic load(input logic [7:0] a, input logic [7:0] b);
      mem.prog[12'h000] = 16'h5100;
      mem.prog[12'h004] = 16'h8000;
      mem.prog[12'h010] = 16'h7000;
      mem.prog[12'h100] = {8'h30, a};
      mem.prog[12'h101] = 16'h4020;
      mem.prog[12'h102] = {8'h30, b};
      mem.prog[12'h103] = 16'h1020;
      mem.prog[12'h104] = 16'h4021;
      mem.prog[12'h105] = 16'h6010;
      mem.prog[12'h106] = 16'h9030;
      mem.prog[12'h107] = 16'h30ff;
      mem.prog[12'h108] = 16'h3040;
      mem.prog[12'h109] = 16'h4002;
      mem.prog[12'h140] = 16'h5140;
      mem.prog[12'h141] = 16'h5140;
      mem.ram[8'h20] = ~a;
      mem.ram[8'h21] = ~a;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (resetn && was_run)
         check("phase", {28'h0, ph},
            {28'h0, ph_prev[2:0], ph_prev[3]});
      if (resetn && ph[1])
         trace.push_back(pm_addr);
      ph_prev <= ph;
      was_run <= resetn;
   end

   initial begin
      repeat (4000) @(posedge mclk);
      n_errors++;
      results();
   end

   initial begin
      seed_ok = $urandom(32'h046fa160);
      for (int it = 0; it < 3; it++) begin
         x = (it == 0) ? 8'hff : 8'($urandom);
         y = (it == 0) ? 8'h01 : 8'($urandom);
         s9 = add9(x, y);
         resetn <= 1'b0;
         slow <= (it == 1);
         load(x, y);
         repeat (6) @(posedge mclk);
         trace.delete();
         resetn <= 1'b1;
         while (trace.size() < 20) @(posedge mclk);
         for (int i = 0; i < 20; i++)
            check("fetch", {20'h0, trace[i]},
               {20'h0, EXP[i]});
         check("ram20", {24'h0, mem.ram[8'h20]}, {24'h0, x});
         check("ram21", {24'h0, mem.ram[8'h21]},
            {24'h0, s9[7:0]});
         ahb(1'b0, `MSEQ_OFF_STAT, 32'h0, rd);
         check("carry", {31'h0, rd[16 + `MSEQ_ST_C]}, {31'h0, s9[8]});
         check("page", {28'h0, rd[11:8]}, 32'h1);
         ahb(1'b1, `MSEQ_OFF_ACCUM, 32'hff, rd);
         ahb(1'b0, `MSEQ_OFF_ACCUM, 32'h0, rd);
         check("accum", rd, 32'h40);
         ahb(1'b0, 8'h10, 32'h0, rd);
         check("unmapped", rd, 32'h0);
      end
      // one-cycle request: the latched flag must carry it to the ack
      ahb(1'b1, `MSEQ_OFF_CTRL, 32'h7, rd);
      @(posedge mclk);
      int_req <= 1'b1;
      @(posedge mclk);
      int_req <= 1'b0;
      while (pm_addr !== `MSEQ_INT_VEC) @(posedge mclk);
      ahb(1'b0, `MSEQ_OFF_CTRL, 32'h0, rd);
      check("ctrl_ack", rd, 32'h5);
      while (pm_addr !== 12'h140) @(posedge mclk);
      ahb(1'b0, `MSEQ_OFF_CTRL, 32'h0, rd);
      check("ctrl_ret", rd, 32'h7);
      // byte-sized write must be ignored, else the core would halt
      hsize <= 3'h0;
      ahb(1'b1, `MSEQ_OFF_CTRL, 32'h0, rd);
      hsize <= 3'h2;
      ahb(1'b0, `MSEQ_OFF_CTRL, 32'h0, rd);
      check("ctrl_size", rd, 32'h7);
      // six nested calls fill the stack, then a loop holds it full
      resetn <= 1'b0;
      mem.prog[12'h000] = 16'h6020;
      for (int k = 0; k < 5; k++)
         mem.prog[12'h020 + k] = 16'h6021 + 16'(k);
      mem.prog[12'h025] = 16'h5025;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      while (pm_addr !== 12'h026) @(posedge mclk);
      ahb(1'b1, `MSEQ_OFF_CTRL, 32'h7, rd);
      int_req <= 1'b1;
      @(posedge mclk);
      int_req <= 1'b0;
      repeat (16) @(posedge mclk);
      ahb(1'b0, `MSEQ_OFF_STAT, 32'h0, rd);
      check("flag_full", {31'h0, rd[20]}, 32'h1);
      check("pc_full", {24'h0, rd[11:4]}, 32'h2);
      // a return frees a level, so the held request is served
      mem.prog[12'h025] = 16'h7000;
      while (pm_addr !== `MSEQ_INT_VEC) @(posedge mclk);
      ahb(1'b0, `MSEQ_OFF_CTRL, 32'h0, rd);
      check("ctrl_full", rd, 32'h5);
      results();
   end
endmodule
